// ==== hdl/bk2c_top.sv ====
// Operation
// (RULE1) ramp codes 00/01/10 step voltage once per 32us/16us/8us
// (RULE2) ramp code 11 applies new target voltage immediately
// (RULE3) clock phase bit: 0 normal, 1 inverted, resets to 1
// (RULE4) frequency field: 01 is 2.0MHz, 10 is 4.0MHz, others reserved
// (RULE5) frequency field written only during configuration load
// (RULE6) when disabled: discharge output if float bit 0, else float
// (RULE7) start-up walks current limit through 8 stages of 32-256us
// (RULE8) capacitor field only code 10, written only by configuration load
// (RULE9) undervoltage: 00 ignore, 01 converter off, 10 system reset
// (RULE10) every undervoltage event raises an interrupt; the code always sets status bit 0, but irq_o rises only when IEN bit 0 is set
// (RULE11) hw-control source: off, input 1, input 2, or either
// (RULE12) hw-control asserted: ON code if bit 0, SLEEP code if 1
// (RULE13) hw-control mode: 00 CCM, 01 off, 10 LDO, 11 hysteretic
// (RULE14) high-current level 250mA to 2000mA in 250mA steps
// (RULE15) high-current detect only while enable bit is 1
// (RULE16) voltage code seven bits, one code per 12.5mV step
// (RULE17) paced ramp steps monotonically, stops at target
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "bk2c_defines.svh"

module bk2c_top
    import bk2c_pkg::*;
#(
    parameter int VW = 7,
    parameter int TICK_CYC = `BK2C_TICK_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic cfg_load_i,
    input wire logic hw_ctrl1_i,
    input wire logic hw_ctrl2_i,
    input wire logic uv_event_i,
    input wire logic hc_event_i,
    output logic [15:0] rdata_o,
    output logic irq_o,
    output logic sys_reset_req_o,
    output logic [VW-1:0] vout_code_o,
    output bk2c_stage_s stage_o
);
    // reset words are in register layout, fields are picked out below
    localparam logic [15:0] C1R = `BK2C_CTRL1_RST;
    localparam logic [15:0] C2R = `BK2C_CTRL2_RST;
    bk2c_ctrl1_s c1_ff;
    bk2c_ctrl2_s c2_ff;
    logic [VW-1:0] on_vcode_ff;
    logic [VW-1:0] slp_vcode_ff;
    logic sw_en_ff;
    logic uv_off_ff;
    logic [`BK2C_NUM_EV-1:0] stat_ff;
    logic [`BK2C_NUM_EV-1:0] ien_ff;
    logic [15:0] tick_cnt_ff;
    logic tick_ff;
    logic [4:0] ramp_cnt_ff;
    logic [VW-1:0] vout_ff;
    bk2c_state_e state_ff;
    logic [2:0] stage_ff;
    logic [5:0] ss_cnt_ff;
    logic [15:0] nxt_rdata;
    logic [VW-1:0] target;
    logic hwc_act;
    logic en_req;
    logic [4:0] ramp_div;
    logic [5:0] ss_div;
    logic [`BK2C_NUM_EV-1:0] ev;
    logic wr1;
    logic wr2;

    assign wr1 = wr_i && addr_i == `BK2C_ADDR_CTRL1;
    assign wr2 = wr_i && addr_i == `BK2C_ADDR_CTRL2;

    // (RULE11) source select
    always_comb begin
        case (c2_ff.hw_control_input_sel)
            `BK2C_HWC_IN1: hwc_act = hw_ctrl1_i;
            `BK2C_HWC_IN2: hwc_act = hw_ctrl2_i;
            `BK2C_HWC_ANY: hwc_act = hw_ctrl1_i | hw_ctrl2_i;
            default: hwc_act = 1'b0;
        endcase
    end

    // (RULE12) hw-control voltage choice
    assign target = (hwc_act && c2_ff.hw_control_voltage_choice)
        ? slp_vcode_ff : on_vcode_ff;

    // (RULE13) hw-control mode 01 disables; (RULE9) uv shutdown latch
    assign en_req = sw_en_ff && !uv_off_ff &&
        !(hwc_act && c2_ff.hw_control_operating_state == `BK2C_HWM_OFF);

    // (RULE5) (RULE8) config-load-only fields
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            c1_ff <= {C1R[15:14], C1R[12], C1R[9:8], C1R[7], C1R[5:4],
                C1R[1:0]};
        end else if (wr1) begin
            c1_ff.ramp_step_period <= wdata_i[15:14];
            // (RULE3) phase bit
            c1_ff.switch_clock_invert <= wdata_i[12];
            c1_ff.output_float_on_disable <= wdata_i[7];
            c1_ff.softstart_step_duration <= wdata_i[5:4];
            if (cfg_load_i) begin
                c1_ff.switching_frequency_sel <= wdata_i[9:8];
                c1_ff.output_capacitor_range <= wdata_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            c2_ff <= {C2R[15:14], C2R[12:11], C2R[10], C2R[9:8], C2R[6:4],
                C2R[0]};
        end else if (wr2) begin
            c2_ff <= {wdata_i[15:14], wdata_i[12:11], wdata_i[10],
                wdata_i[9:8], wdata_i[6:4], wdata_i[0]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            on_vcode_ff <= '0;
            slp_vcode_ff <= '0;
            sw_en_ff <= 1'b0;
            ien_ff <= '0;
        end else if (wr_i) begin
            if (addr_i == `BK2C_ADDR_ONV) on_vcode_ff <= wdata_i[VW-1:0];
            if (addr_i == `BK2C_ADDR_SLPV) slp_vcode_ff <= wdata_i[VW-1:0];
            if (addr_i == `BK2C_ADDR_CMD) sw_en_ff <= wdata_i[0];
            if (addr_i == `BK2C_ADDR_IEN) begin
                ien_ff <= wdata_i[`BK2C_NUM_EV-1:0];
            end
        end
    end

    // (RULE9) action on undervoltage; re-enable clears shutdown
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            uv_off_ff <= 1'b0;
            sys_reset_req_o <= 1'b0;
        end else begin
            sys_reset_req_o <= uv_event_i &&
                c2_ff.undervoltage_response == `BK2C_UV_SYS;
            if (uv_event_i &&
                c2_ff.undervoltage_response == `BK2C_UV_CONV) begin
                uv_off_ff <= 1'b1;
            end else if (wr_i && addr_i == `BK2C_ADDR_CMD && wdata_i[0]) begin
                uv_off_ff <= 1'b0;
            end
        end
    end

    // 8us tick divider, base unit of ramp and soft-start pacing
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || tick_cnt_ff == 16'(TICK_CYC - 1)) begin
            tick_cnt_ff <= '0;
            tick_ff <= !rst_i;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    // (RULE1) 00:4 ticks, 01:2, 10:1
    assign ramp_div = 5'h4 >> c1_ff.ramp_step_period;

    // (RULE7) stage length 4,8,16,32 ticks
    assign ss_div = 6'(`BK2C_SS_BASE_TICKS) << c1_ff.softstart_step_duration;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            vout_ff <= '0;
            ramp_cnt_ff <= '0;
        end else if (c1_ff.ramp_step_period == `BK2C_RATE_IMM) begin
            // (RULE2) immediate change
            vout_ff <= target;
            ramp_cnt_ff <= '0;
        end else if (vout_ff == target) begin
            // (RULE17) stop at target
            ramp_cnt_ff <= '0;
        end else if (tick_ff) begin
            if (ramp_cnt_ff + 5'h01 >= ramp_div) begin
                ramp_cnt_ff <= '0;
                // (RULE16) (RULE17) one code step toward target
                vout_ff <= (vout_ff < target) ? vout_ff + 1'b1
                    : vout_ff - 1'b1;
            end else begin
                ramp_cnt_ff <= ramp_cnt_ff + 5'h01;
            end
        end
    end

    // (RULE7) soft-start stage sequencer
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !en_req) begin
            state_ff <= BK2C_OFF;
            stage_ff <= '0;
            ss_cnt_ff <= '0;
        end else begin
            case (state_ff)
                BK2C_OFF: state_ff <= BK2C_SOFT;
                BK2C_SOFT: begin
                    if (tick_ff) begin
                        if (ss_cnt_ff + 6'h01 >= ss_div) begin
                            ss_cnt_ff <= '0;
                            if (stage_ff == 3'(`BK2C_SS_STAGES - 1)) begin
                                state_ff <= BK2C_RUN;
                            end else begin
                                stage_ff <= stage_ff + 3'h1;
                            end
                        end else begin
                            ss_cnt_ff <= ss_cnt_ff + 6'h01;
                        end
                    end
                end
                BK2C_RUN: state_ff <= BK2C_RUN;
                default: state_ff <= BK2C_OFF;
            endcase
        end
    end

    assign ev[`BK2C_ST_UV] = uv_event_i;
    // (RULE15) detection gated by enable
    assign ev[`BK2C_ST_HC] = hc_event_i && c2_ff.high_current_detect_on;
    assign ev[`BK2C_ST_SS] = state_ff == BK2C_SOFT && tick_ff &&
        ss_cnt_ff + 6'h01 >= ss_div && stage_ff == 3'(`BK2C_SS_STAGES - 1);

    // (RULE10) sticky status, set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= ev | (stat_ff & ~((wr_i &&
                addr_i == `BK2C_ADDR_ICLR) ? wdata_i[`BK2C_NUM_EV-1:0]
                : '0));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_ff & ien_ff);
        end
    end

    always_comb begin
        nxt_rdata = 16'h0000;
        case (addr_i)
            `BK2C_ADDR_CTRL1: nxt_rdata = {c1_ff.ramp_step_period, 1'b0,
                c1_ff.switch_clock_invert, 2'b00,
                c1_ff.switching_frequency_sel,
                c1_ff.output_float_on_disable, 1'b0,
                c1_ff.softstart_step_duration, 2'b00,
                c1_ff.output_capacitor_range};
            `BK2C_ADDR_CTRL2: nxt_rdata = {c2_ff.undervoltage_response, 1'b0,
                c2_ff.hw_control_input_sel,
                c2_ff.hw_control_voltage_choice,
                c2_ff.hw_control_operating_state, 1'b0,
                c2_ff.high_current_level, 3'b000,
                c2_ff.high_current_detect_on};
            `BK2C_ADDR_ONV: nxt_rdata = 16'(on_vcode_ff);
            `BK2C_ADDR_SLPV: nxt_rdata = 16'(slp_vcode_ff);
            `BK2C_ADDR_CMD: nxt_rdata = {14'h0000, uv_off_ff, sw_en_ff};
            `BK2C_ADDR_STAT: nxt_rdata = 16'(stat_ff);
            `BK2C_ADDR_IEN: nxt_rdata = 16'(ien_ff);
            `BK2C_ADDR_LVL: nxt_rdata = {8'h00, 1'b0, vout_ff};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !rd_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= nxt_rdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            vout_code_o <= '0;
            stage_o <= '0;
        end else begin
            vout_code_o <= vout_ff;
            stage_o.enable <= state_ff != BK2C_OFF;
            // (RULE6) discharge vs float when disabled
            stage_o.discharge <= state_ff == BK2C_OFF &&
                !c1_ff.output_float_on_disable;
            stage_o.clk_invert <= c1_ff.switch_clock_invert;
            // (RULE4) frequency code passed to power stage
            stage_o.freq_sel <= c1_ff.switching_frequency_sel;
            stage_o.cap_sel <= c1_ff.output_capacitor_range;
            // (RULE13) hw-control operating mode
            stage_o.op_mode <= c2_ff.hw_control_operating_state;
            // (RULE15) detector enable
            stage_o.hc_detect_on <= c2_ff.high_current_detect_on;
            // (RULE14) 250mA per code step plus 250mA
            stage_o.hc_level <= c2_ff.high_current_level;
            stage_o.ilim_stage <= stage_ff;
        end
    end
endmodule : bk2c_top

// ==== hdl/bk2c_defines.svh ====
`ifndef BK2C_DEFINES_SVH
`define BK2C_DEFINES_SVH

// register indices (byte address = index, plain port)
`define BK2C_ADDR_CTRL1 16'h405B
`define BK2C_ADDR_CTRL2 16'h405C
`define BK2C_ADDR_ONV 16'h4060
`define BK2C_ADDR_SLPV 16'h4061
`define BK2C_ADDR_CMD 16'h4062
`define BK2C_ADDR_STAT 16'h4063
`define BK2C_ADDR_IEN 16'h4064
`define BK2C_ADDR_ICLR 16'h4065
`define BK2C_ADDR_LVL 16'h4066

// reset values
`define BK2C_CTRL1_RST 16'h9000
`define BK2C_CTRL2_RST 16'h0300

// times in ns and clock period in ns
`define BK2C_CLK_NS 20
`define BK2C_T8US_NS 8000
`define BK2C_T32US_NS 32000
`define BK2C_TICK_CYC (`BK2C_T8US_NS / `BK2C_CLK_NS)
`define BK2C_SS_BASE_TICKS (`BK2C_T32US_NS / `BK2C_T8US_NS)
`define BK2C_SS_STAGES 8

// ramp codes
`define BK2C_RATE_IMM 2'h3

// undervoltage action codes
`define BK2C_UV_IGNORE 2'h0
`define BK2C_UV_CONV 2'h1
`define BK2C_UV_SYS 2'h2

// hw-control source codes
`define BK2C_HWC_IN1 2'h1
`define BK2C_HWC_IN2 2'h2
`define BK2C_HWC_ANY 2'h3

// hw-control mode code meaning disabled
`define BK2C_HWM_OFF 2'h1

// status bit positions
`define BK2C_ST_UV 0
`define BK2C_ST_HC 1
`define BK2C_ST_SS 2
`define BK2C_NUM_EV 3

`endif

// ==== hdl/bk2c_pkg.sv ====
package bk2c_pkg;
    typedef struct packed {
        logic [1:0] ramp_step_period;
        logic switch_clock_invert;
        logic [1:0] switching_frequency_sel;
        logic output_float_on_disable;
        logic [1:0] softstart_step_duration;
        logic [1:0] output_capacitor_range;
    } bk2c_ctrl1_s;

    typedef struct packed {
        logic [1:0] undervoltage_response;
        logic [1:0] hw_control_input_sel;
        logic hw_control_voltage_choice;
        logic [1:0] hw_control_operating_state;
        logic [2:0] high_current_level;
        logic high_current_detect_on;
    } bk2c_ctrl2_s;

    typedef struct packed {
        logic enable;
        logic discharge;
        logic clk_invert;
        logic [1:0] freq_sel;
        logic [1:0] cap_sel;
        logic [1:0] op_mode;
        logic hc_detect_on;
        logic [2:0] hc_level;
        logic [2:0] ilim_stage;
    } bk2c_stage_s;

    typedef enum logic [1:0] {
        BK2C_OFF = 2'b00,
        BK2C_SOFT = 2'b01,
        BK2C_RUN = 2'b11
    } bk2c_state_e;
endpackage : bk2c_pkg

// ==== testbench/bk2c_chk.sv ====
`timescale 1ns/100ps
`include "bk2c_defines.svh"
module bk2c_chk
    import bk2c_pkg::*;
#(
    parameter int VW = 7,
    parameter int TICK_CYC = 400
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic cfg_load_i,
    input wire logic uv_event_i,
    input wire logic sys_reset_req_o,
    input wire logic [VW-1:0] vout_code_o,
    input wire bk2c_stage_s stage_o
);
    logic [15:0] c1_ff;
    logic [15:0] c2_ff;
    logic [1:0] uv_act;
    logic paced;
    assign uv_act = c2_ff[15:14];
    assign paced = c1_ff[15:14] != `BK2C_RATE_IMM;
    // shadow of the control words, so checks know the programmed fields
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            c1_ff <= `BK2C_CTRL1_RST;
            c2_ff <= `BK2C_CTRL2_RST;
        end else if (wr_i && addr_i == `BK2C_ADDR_CTRL1) begin
            c1_ff <= wdata_i;
        end else if (wr_i && addr_i == `BK2C_ADDR_CTRL2) begin
            c2_ff <= wdata_i;
        end
    end
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    chk_cfg_lock: assert property (
        (!cfg_load_i) [*3] |-> $stable(stage_o.freq_sel)
            && $stable(stage_o.cap_sel))
        else $error("freq or cap moved outside config load");
    chk_ramp_step: assert property (
        paced && $past(stage_o.enable) && stage_o.enable
            && $changed(vout_code_o)
        |-> vout_code_o == $past(vout_code_o) + 7'h1
            || vout_code_o + 7'h1 == $past(vout_code_o))
        else $error("paced ramp moved more than one code");
    chk_ramp_gap: assert property (
        c1_ff[15:14] == 2'h2 && stage_o.enable && $changed(vout_code_o)
        |=> $stable(vout_code_o) [*3])
        else $error("fast ramp stepped early");
    chk_float_dis: assert property (
        !$past(rst_i) && !stage_o.enable && !$past(stage_o.enable)
            && $stable(c1_ff[7]) |-> stage_o.discharge == !c1_ff[7])
        else $error("discharge does not follow float bit");
    chk_phase_sel: assert property (
        !$past(rst_i) && $stable(c1_ff[12])
        |-> stage_o.clk_invert == c1_ff[12])
        else $error("clock phase does not follow its bit");
    chk_hc_cfg: assert property (
        wr_i && addr_i == `BK2C_ADDR_CTRL2 |-> ##2
            {stage_o.hc_level, stage_o.hc_detect_on} == {c2_ff[6:4], c2_ff[0]})
        else $error("high current setting not applied");
    chk_sys_rst: assert property (
        uv_event_i && uv_act == `BK2C_UV_SYS |=> sys_reset_req_o)
        else $error("no system reset request");
    chk_rst_cause: assert property (
        sys_reset_req_o |-> $past(uv_event_i) && $past(uv_act) == `BK2C_UV_SYS)
        else $error("system reset request without cause");
    chk_uv_shut: assert property (
        uv_event_i && uv_act == `BK2C_UV_CONV |-> ##[1:3] !stage_o.enable)
        else $error("converter not shut down");
    cover property (uv_event_i && uv_act == `BK2C_UV_SYS);
    cover property (paced && $changed(vout_code_o));
    cover property (cfg_load_i && wr_i);
endmodule : bk2c_chk

bind bk2c_top bk2c_chk #(.VW(VW), .TICK_CYC(TICK_CYC)) u_chk (.*);

// ==== testbench/bk2c_stage_model.sv ====
`timescale 1ns/100ps
module bk2c_stage_model
    import bk2c_pkg::*;
(
    input wire logic clk_sys_i,
    input wire bk2c_stage_s stage_i,
    input wire logic uv_req_i,
    input wire logic [11:0] load_ma_i,
    output logic uv_event_o,
    output logic hc_event_o
);
    always_ff @(posedge clk_sys_i) begin
        uv_event_o <= uv_req_i;
    end
    // quarter amp per code
    // comparator ignores the enable bit: gating is the block's job
    always_ff @(posedge clk_sys_i) begin
        hc_event_o <= load_ma_i > 12'hFA * (12'(stage_i.hc_level) + 12'h1);
    end
endmodule : bk2c_stage_model

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`include "bk2c_defines.svh"
module testbench import bk2c_pkg::*;;
    localparam int TK = 4;
    logic clk_sys_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0;
    logic cfg_load_i = 1'h0, hw_ctrl1_i = 1'h0, hw_ctrl2_i = 1'h0;
    logic uv_req = 1'h0, cf, uv_event_i, hc_event_i, irq_o, sys_reset_req_o;
    logic [11:0] load_ma = 12'h0;
    logic [15:0] addr_i = 16'h0, wdata_i = 16'h0, rdata_o, d, c1, w;
    logic [6:0] vout_code_o, tgt;
    bk2c_stage_s stage_o;
    int fail_count = 0, total_checks = 0, srn = 0, cyc, t0;
    bk2c_top #(.TICK_CYC(TK)) uut (.clk_sys_i, .rst_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .cfg_load_i, .hw_ctrl1_i, .hw_ctrl2_i, .uv_event_i,
        .hc_event_i, .rdata_o, .irq_o, .sys_reset_req_o, .vout_code_o,
        .stage_o);
    bk2c_stage_model u_pwr (.clk_sys_i, .stage_i(stage_o), .uv_req_i(uv_req),
        .load_ma_i(load_ma), .uv_event_o(uv_event_i), .hc_event_o(hc_event_i));
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (sys_reset_req_o === 1'h1) srn++;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'h1;
        @(posedge clk_sys_i);
        wr_i <= 1'h0;
    endtask : wr
    task rd(input logic [15:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge clk_sys_i);
        rd_i <= 1'h0;
        #1 d = rdata_o;
    endtask : rd
    task settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : settle
    task wchg();
        #1 tgt = vout_code_o;
        for (cyc = 0; vout_code_o === tgt && cyc < 500; cyc++) settle(1);
    endtask : wchg
    task uvp();
        @(posedge clk_sys_i);
        uv_req <= 1'h1;
        @(posedge clk_sys_i);
        uv_req <= 1'h0;
    endtask : uvp
    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        #(20 * 30000);
        fail_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hC403));
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'h0;
        rd(16'h4067);
        chk(d, 16'h0);
        c1 = `BK2C_CTRL1_RST;
        for (int i = 0; i < 8; i++) begin
            w = i ? 16'($urandom) : 16'hFFFF;
            cf = i ? 1'($urandom) : 1'h0;
            @(posedge clk_sys_i);
            cfg_load_i <= cf;
            c1 = cf ? w & 16'hD3B3 : (w & 16'hD0B0) | (c1 & 16'h0303);
            wr(`BK2C_ADDR_CTRL1, w);
            rd(`BK2C_ADDR_CTRL1);
            chk(d, c1);
            chk(16'({stage_o.freq_sel, stage_o.cap_sel}), 16'({c1[9:8], c1[1:0]}));
            chk(16'(stage_o.clk_invert), 16'(c1[12]));
            chk(16'(stage_o.discharge), 16'(!c1[7]));
        end
        @(posedge clk_sys_i);
        cfg_load_i <= 1'h1;
        wr(`BK2C_ADDR_CTRL1, 16'h9102);
        cfg_load_i <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            w = i ? 16'($urandom) : 16'hFFFF;
            wr(`BK2C_ADDR_CTRL2, w);
            rd(`BK2C_ADDR_CTRL2);
            chk(d, w & 16'hDF71);
            chk(16'({stage_o.hc_level, stage_o.hc_detect_on}), 16'({w[6:4], w[0]}));
        end
        wr(`BK2C_ADDR_CTRL2, 16'h0300);
        $display("test registers done");
        wr(`BK2C_ADDR_CMD, 16'h0001);
        t0 = $time;
        do rd(`BK2C_ADDR_STAT); while (d[2] !== 1'h1 && $time - t0 < 8000);
        chk(16'((($time - t0) / 20) inside {[125:140]}), 16'h1);
        $display("test softstart done");
        for (int r = 0; r < 3; r++) begin
            wr(`BK2C_ADDR_CTRL1, {2'(r), 14'h1102});
            wr(`BK2C_ADDR_ONV, r == 1 ? 16'h4 : 16'(20 * r + 10));
            wchg();
            wchg();
            chk(16'(cyc), 16'(TK * (4 >> r)));
            repeat (60) if (vout_code_o !== wdata_i[6:0]) wchg();
            settle(20);
            chk(16'(vout_code_o), wdata_i);
        end
        wr(`BK2C_ADDR_CTRL1, 16'hD102);
        wr(`BK2C_ADDR_ONV, 16'h0005);
        settle(2);
        chk(16'(vout_code_o), 16'h5);
        $display("test ramp done");
        for (int a = 0; a < 4; a++) begin
            wr(`BK2C_ADDR_CTRL2, {2'(a % 3), 14'h0300});
            wr(`BK2C_ADDR_IEN, 16'(a < 3));
            cyc = srn;
            uvp();
            settle(3);
            chk(16'(irq_o), 16'(a < 3));
            chk(16'(srn - cyc), 16'(a == 2));
            if (a < 2) chk(16'(stage_o.enable), 16'(a == 0));
            rd(`BK2C_ADDR_STAT);
            chk(16'(d[0]), 16'h1);
            wr(`BK2C_ADDR_ICLR, 16'h0001);
            wr(`BK2C_ADDR_CMD, 16'h0001);
            settle(2);
            chk(16'(irq_o), 16'h0);
        end
        $display("test undervoltage done");
        wr(`BK2C_ADDR_SLPV, 16'h0014);
        wr(`BK2C_ADDR_ONV, 16'h000A);
        for (int i = 0; i < 18; i++) begin
            wr(`BK2C_ADDR_CTRL2, i < 16 ? {3'h0, 2'(i >> 2), 11'h700} : 16'h0900);
            @(posedge clk_sys_i);
            hw_ctrl1_i <= i[0];
            hw_ctrl2_i <= i[1];
            settle(3);
            if (i < 16) chk(16'(vout_code_o), (i[2] & i[0]) | (i[3] & i[1]) ? 16'h14 : 16'hA);
        end
        chk(16'(stage_o.enable), 16'h0);
        $display("test hw control done");
        for (int i = 0; i < 3; i++) begin
            wr(`BK2C_ADDR_CTRL2, i < 2 ? 16'h0331 : 16'h0330);
            @(posedge clk_sys_i);
            load_ma <= i == 1 ? 12'h384 : 12'h44C;
            settle(3);
            wr(`BK2C_ADDR_ICLR, 16'h0002);
            rd(`BK2C_ADDR_STAT);
            chk(16'(d[1]), 16'(i == 0));
        end
        $display("test high current done");
        end_sim();
    end
endmodule : testbench
